/* src/csg_map.vh */
// Constants shared by the clock strap latch and gating logic.
`ifndef CSG_MAP_VH
`define CSG_MAP_VH

// Timing of the strap selection period.
`define CSG_ACLK_MHZ 250
`define CSG_SEL_PERIOD_US 2000
`define CSG_REF_CLK_KHZ 14318
`define CSG_SEL_REF_CYCLES ((`CSG_SEL_PERIOD_US * `CSG_REF_CLK_KHZ) / 1000)
`define CSG_SEL_CNT_W 16

// Sampling depth of the stop inputs, in sample-clock rising edges.
`define CSG_PCI_STOP_STAGES 1
`define CSG_CLK_STOP_STAGES 2

// Register map, byte addresses.
`define CSG_ADDR_W 4
`define CSG_ADDR_STATUS 4'h0
`define CSG_ADDR_CTRL 4'h4

// Control register fields and reset value.
`define CSG_CTRL_PCI_DIS 0
`define CSG_CTRL_MEM_DIS 1
`define CSG_CTRL_CPU_DIS 2
`define CSG_CTRL_W 3
`define CSG_CTRL_RESET 3'h0

// Status register fields.
`define CSG_ST_FS_LSB 0
`define CSG_ST_MODE 4
`define CSG_ST_LATCHED 5
`define CSG_ST_DRIVE 6
`define CSG_ST_PCI_RUN 7
`define CSG_ST_MEM_RUN 8
`define CSG_ST_CPU_RUN 9

// AXI responses.
`define CSG_RESP_OKAY 2'h0
`define CSG_RESP_SLVERR 2'h2

`endif

/* src/csg_sel_timer.v */
// Selection-period timer that counts reference clock edges after power detect.
`timescale 1ns/1ps
`default_nettype none
module csg_sel_timer #(
    parameter CW = 16,
    parameter SEL_CYCLES = 28636
) (
    // Clock and power detect
    input wire aclk,
    input wire power_good,
    // Reference clock level
    input wire ref_clk,
    // Results
    output wire capture_strobe,
    output wire done
);
    localparam [CW-1:0] LAST = SEL_CYCLES - 1;
    reg ref_prev_q;
    reg [CW-1:0] cnt_q;
    reg done_q;
    reg strobe_q;

    // Only a power-down clears the timer, so the capture happens once per power-up.
    always @(posedge aclk) begin
        if (!power_good) begin
            // Tracking the level here keeps a high level at power-up from counting as an edge.
            ref_prev_q <= ref_clk;
            cnt_q <= {CW{1'b0}};
            done_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_clk;
            strobe_q <= 1'b0;
            if (!done_q && ref_clk && !ref_prev_q) begin
                if (cnt_q == LAST) begin
                    done_q <= 1'b1;
                    strobe_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    assign capture_strobe = strobe_q;
    assign done = done_q;
endmodule
`default_nettype wire

/* src/csg_stop_gate.v */
// Stop-input sampler and glitch-free enable for a group of gated clocks.
`timescale 1ns/1ps
`default_nettype none
module csg_stop_gate #(
    parameter STAGES = 2
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Sampling clock, gated source clock and run request
    input wire sample_clk,
    input wire src_clk,
    input wire run_req,
    // Enable for the gated copies
    output wire run_en
);
    reg sample_prev_q;
    reg [STAGES-1:0] pipe_q;
    reg run_en_q;
    wire sample_rise;

    assign sample_rise = sample_clk & ~sample_prev_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            sample_prev_q <= sample_clk;
        end else begin
            sample_prev_q <= sample_clk;
        end
    end

    // Each stage advances on a rising edge of the sampling clock.
    genvar i;
    generate
        for (i = 0; i < STAGES; i = i + 1) begin : g_stage
            always @(posedge aclk) begin
                if (!aresetn) begin
                    pipe_q[i] <= 1'b0;
                end else if (sample_rise) begin
                    pipe_q[i] <= (i == 0) ? run_req : pipe_q[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    // The enable moves only while the source is low, so no high phase is cut short.
    always @(posedge aclk) begin
        if (!aresetn) begin
            run_en_q <= 1'b0;
        end else if (!src_clk) begin
            run_en_q <= pipe_q[STAGES-1];
        end
    end

    assign run_en = run_en_q;
endmodule
`default_nettype wire

/* src/csg_clock_strap.v */
// Top of the clock strap latch and output gating block with its AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "csg_map.vh"
module csg_clock_strap #(
    parameter SEL_CYCLES = `CSG_SEL_REF_CYCLES
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Power detect, high once the supply is above threshold
    input wire power_good,
    // Clock sources, sampled as synchronous levels
    input wire ref_clk_in,
    input wire pci_clk_in,
    input wire cpu_clk_in,
    input wire clk24_in,
    input wire clk48_in,
    input wire mem_clk_source,
    // Clock-stop input, active low
    input wire clk_stop_n,
    // Dual pin: 24 MHz output / select bit 0
    input wire freq_sel_bit0_in,
    output wire freq_sel_bit0_out,
    output wire freq_sel_bit0_oe,
    // Dual pin: 48 MHz output / select bit 1
    input wire freq_sel_bit1_in,
    output wire freq_sel_bit1_out,
    output wire freq_sel_bit1_oe,
    // Dual pin: second reference output / select bit 2
    input wire freq_sel_bit2_in,
    output wire freq_sel_bit2_out,
    output wire freq_sel_bit2_oe,
    // Dual pin: PCI output 0 / select bit 3
    input wire freq_sel_bit3_in,
    output wire freq_sel_bit3_out,
    output wire freq_sel_bit3_oe,
    // Dual pin: free PCI output / mode strap
    input wire mode_pin_in,
    output wire mode_pin_out,
    output wire mode_pin_oe,
    // Shared pin: first reference output or PCI stop input
    input wire fixed_ref_out_a_in,
    output wire fixed_ref_out_a_out,
    output wire fixed_ref_out_a_oe,
    // Clock outputs
    output wire [4:0] pci_clk_gated,
    output wire [1:0] cpu_clk_gated,
    output wire cpu_clk_free,
    output wire [15:0] mem_clk_gated,
    output wire mem_clk_free,
    // Latched straps
    output wire [3:0] freq_sel_code,
    output wire mode_strap,
    // AXI4-Lite write address
    input wire [`CSG_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [`CSG_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);
    wire capture_strobe;
    wire timer_done;
    wire pci_en;
    wire mem_en;
    wire cpu_en;
    wire pci_stop_level;
    wire pci_run_req;
    wire mem_run_req;
    wire cpu_run_req;

    reg [4:0] straps_q;
    reg latched_q;
    reg drive_q;

    reg fs0_out_q;
    reg fs1_out_q;
    reg fs2_out_q;
    reg fs3_out_q;
    reg mode_out_q;
    reg ref_a_out_q;
    reg ref_a_oe_q;
    reg [4:0] pci_q;
    reg [1:0] cpu_q;
    reg cpu_free_q;
    reg [15:0] mem_q;
    reg mem_free_q;

    reg [`CSG_CTRL_W-1:0] ctrl_q;
    reg awready_q;
    reg wready_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [`CSG_ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg arready_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    reg [31:0] rd_word;
    reg rd_ok;

    csg_sel_timer #(
        .CW(`CSG_SEL_CNT_W),
        .SEL_CYCLES(SEL_CYCLES)
    ) u_timer (
        .aclk(aclk),
        .power_good(power_good),
        .ref_clk(ref_clk_in),
        .capture_strobe(capture_strobe),
        .done(timer_done)
    );

    // Straps and the driver enable survive the bus reset; only power-down clears them.
    always @(posedge aclk) begin
        if (!power_good) begin
            straps_q <= 5'h00;
            latched_q <= 1'b0;
            drive_q <= 1'b0;
            ref_a_oe_q <= 1'b0;
        end else begin
            if (capture_strobe) begin
                straps_q <= {mode_pin_in, freq_sel_bit3_in, freq_sel_bit2_in,
                             freq_sel_bit1_in, freq_sel_bit0_in};
                latched_q <= 1'b1;
            end
            drive_q <= latched_q;
            ref_a_oe_q <= drive_q & straps_q[4];
        end
    end

    // Drivers stay off until one cycle after the capture.
    assign freq_sel_bit0_oe = drive_q;
    assign freq_sel_bit1_oe = drive_q;
    assign freq_sel_bit2_oe = drive_q;
    assign freq_sel_bit3_oe = drive_q;
    assign mode_pin_oe = drive_q;

    assign freq_sel_code = straps_q[3:0];
    assign mode_strap = straps_q[4];

    // In mode 0 the shared pin is the PCI stop input; in mode 1 only the PCI disable bit stops the PCI outputs.
    assign pci_stop_level = straps_q[4] ? 1'b1 : fixed_ref_out_a_in;
    assign pci_run_req = pci_stop_level & ~ctrl_q[`CSG_CTRL_PCI_DIS];
    assign mem_run_req = clk_stop_n & ~ctrl_q[`CSG_CTRL_MEM_DIS];
    assign cpu_run_req = clk_stop_n & ~ctrl_q[`CSG_CTRL_CPU_DIS];

    csg_stop_gate #(
        .STAGES(`CSG_PCI_STOP_STAGES)
    ) u_pci_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_clk(pci_clk_in),
        .src_clk(pci_clk_in),
        .run_req(pci_run_req),
        .run_en(pci_en)
    );

    csg_stop_gate #(
        .STAGES(`CSG_CLK_STOP_STAGES)
    ) u_mem_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_clk(cpu_clk_in),
        .src_clk(mem_clk_source),
        .run_req(mem_run_req),
        .run_en(mem_en)
    );

    csg_stop_gate #(
        .STAGES(`CSG_CLK_STOP_STAGES)
    ) u_cpu_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_clk(cpu_clk_in),
        .src_clk(cpu_clk_in),
        .run_req(cpu_run_req),
        .run_en(cpu_en)
    );

    // Output flip-flops; memory copies follow their source without waiting for drive_q, all others are gated by it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            fs0_out_q <= 1'b0;
            fs1_out_q <= 1'b0;
            fs2_out_q <= 1'b0;
            fs3_out_q <= 1'b0;
            mode_out_q <= 1'b0;
            ref_a_out_q <= 1'b0;
            pci_q <= 5'h00;
            cpu_q <= 2'h0;
            cpu_free_q <= 1'b0;
            mem_q <= 16'h0000;
            mem_free_q <= 1'b0;
        end else begin
            fs0_out_q <= drive_q & clk24_in;
            fs1_out_q <= drive_q & clk48_in;
            fs2_out_q <= drive_q & ref_clk_in;
            fs3_out_q <= drive_q & pci_clk_in & pci_en;
            mode_out_q <= drive_q & pci_clk_in;
            ref_a_out_q <= drive_q & straps_q[4] & ref_clk_in;
            pci_q <= {5{drive_q & pci_clk_in & pci_en}};
            cpu_free_q <= drive_q & cpu_clk_in;
            cpu_q <= {2{drive_q & cpu_clk_in & cpu_en}};
            mem_q <= {16{mem_clk_source & mem_en}};
            mem_free_q <= mem_clk_source;
        end
    end

    assign freq_sel_bit0_out = fs0_out_q;
    assign freq_sel_bit1_out = fs1_out_q;
    assign freq_sel_bit2_out = fs2_out_q;
    assign freq_sel_bit3_out = fs3_out_q;
    assign mode_pin_out = mode_out_q;
    assign fixed_ref_out_a_out = ref_a_out_q;
    assign fixed_ref_out_a_oe = ref_a_oe_q;
    assign pci_clk_gated = pci_q;
    assign cpu_clk_gated = cpu_q;
    assign cpu_clk_free = cpu_free_q;
    assign mem_clk_gated = mem_q;
    assign mem_clk_free = mem_free_q;

    // Write channel: address and data are taken in either order, response follows both.
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= {`CSG_ADDR_W{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `CSG_RESP_OKAY;
            ctrl_q <= `CSG_CTRL_RESET;
        end else begin
            if (awready_q && s_axi_awvalid) begin
                awready_q <= 1'b0;
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (wready_q && s_axi_wvalid) begin
                wready_q <= 1'b0;
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (aw_hold_q && w_hold_q && !bvalid_q) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                if (awaddr_q == `CSG_ADDR_CTRL) begin
                    bresp_q <= `CSG_RESP_OKAY;
                    if (wstrb_q[0]) begin
                        ctrl_q <= wdata_q[`CSG_CTRL_W-1:0];
                    end
                end else if (awaddr_q == `CSG_ADDR_STATUS) begin
                    bresp_q <= `CSG_RESP_OKAY;
                end else begin
                    bresp_q <= `CSG_RESP_SLVERR;
                end
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always @* begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `CSG_ADDR_STATUS: begin
                rd_word[`CSG_ST_FS_LSB+3:`CSG_ST_FS_LSB] = straps_q[3:0];
                rd_word[`CSG_ST_MODE] = straps_q[4];
                rd_word[`CSG_ST_LATCHED] = latched_q;
                rd_word[`CSG_ST_DRIVE] = drive_q;
                rd_word[`CSG_ST_PCI_RUN] = pci_en;
                rd_word[`CSG_ST_MEM_RUN] = mem_en;
                rd_word[`CSG_ST_CPU_RUN] = cpu_en;
            end
            `CSG_ADDR_CTRL: begin
                rd_word[`CSG_CTRL_W-1:0] = ctrl_q;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `CSG_RESP_OKAY;
        end else begin
            if (arready_q && s_axi_arvalid) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_ok ? `CSG_RESP_OKAY : `CSG_RESP_SLVERR;
            end
            if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

/* bench/csg_clock_strap_props.sv */
// Concurrent checks on the ports of the clock strap block.
`timescale 1ns/1ps
`default_nettype none
module csg_clock_strap_props #(
    parameter SEL_CYCLES = 8
) (
    // Clock, reset and power detect
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_good,
    // Sources and stop inputs
    input wire logic ref_clk_in,
    input wire logic clk24_in,
    input wire logic mem_clk_source,
    input wire logic clk_stop_n,
    input wire logic fixed_ref_out_a_in,
    // Dual pins
    input wire logic freq_sel_bit0_in,
    input wire logic freq_sel_bit1_in,
    input wire logic freq_sel_bit2_in,
    input wire logic freq_sel_bit3_in,
    input wire logic mode_pin_in,
    input wire logic freq_sel_bit0_out,
    input wire logic freq_sel_bit0_oe,
    input wire logic mode_pin_out,
    input wire logic mode_pin_oe,
    input wire logic fixed_ref_out_a_out,
    input wire logic fixed_ref_out_a_oe,
    // Clock outputs and straps
    input wire logic [4:0] pci_clk_gated,
    input wire logic [15:0] mem_clk_gated,
    input wire logic mem_clk_free,
    input wire logic [3:0] freq_sel_code,
    input wire logic mode_strap
);
    logic ref_q;
    logic [4:0] pins_q;
    logic [16:0] edges_q;
    logic [5:0] pstop_q;
    logic [5:0] cstop_q;

    // Reference rises since power detect, and how long each stop input has been low.
    always_ff @(posedge aclk) begin
        ref_q <= ref_clk_in;
        pins_q <= {mode_pin_in, freq_sel_bit3_in, freq_sel_bit2_in, freq_sel_bit1_in,
                   freq_sel_bit0_in};
        if (!power_good) edges_q <= 17'h0;
        else if (ref_clk_in && !ref_q && edges_q < SEL_CYCLES) edges_q <= edges_q + 17'h1;
        pstop_q <= (fixed_ref_out_a_in || mode_strap) ? 6'h0 : pstop_q + {5'h0, pstop_q != 6'h3f};
        cstop_q <= clk_stop_n ? 6'h0 : cstop_q + {5'h0, cstop_q != 6'h3f};
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pins_held: assert property (edges_q < SEL_CYCLES |-> !freq_sel_bit0_oe && !mode_pin_oe)
        else $error("dual pin driven early");
    a_drive_on_time: assert property ($rose(edges_q == SEL_CYCLES) |-> ##[1:8] freq_sel_bit0_oe)
        else $error("drivers not enabled");
    a_strap_levels: assert property ($rose(freq_sel_bit0_oe) |-> {mode_strap, freq_sel_code} == pins_q && $stable(freq_sel_code) && !freq_sel_bit0_out)
        else $error("strap capture wrong");
    a_strap_hold: assert property (power_good && $past(power_good) && $past(freq_sel_bit0_oe) |-> $stable(freq_sel_code) && $stable(mode_strap))
        else $error("strap changed");
    a_shared_out: assert property (power_good && $past(power_good) && fixed_ref_out_a_oe |-> mode_strap && freq_sel_bit0_oe)
        else $error("shared pin driven in stop mode");
    a_shared_pick: assert property (power_good && freq_sel_bit0_oe && $past(freq_sel_bit0_oe) |-> fixed_ref_out_a_oe == mode_strap)
        else $error("shared pin function wrong");
    a_ref_follow: assert property ($past(aresetn) && fixed_ref_out_a_oe && $past(fixed_ref_out_a_oe) |-> fixed_ref_out_a_out == $past(ref_clk_in))
        else $error("shared pin not reference");
    a_clk24_follow: assert property ($past(aresetn) && freq_sel_bit0_oe && $past(freq_sel_bit0_oe) |-> freq_sel_bit0_out == $past(clk24_in))
        else $error("24 MHz pin wrong");
    a_pci_stop: assert property (pstop_q == 6'h28 |-> pci_clk_gated == 5'h0)
        else $error("PCI outputs not stopped");
    a_pci_whole: assert property ($changed(pci_clk_gated[0]) |-> $changed(mode_pin_out))
        else $error("PCI gated pulse cut");
    a_mem_whole: assert property ($changed(mem_clk_gated[0]) |-> $changed(mem_clk_free))
        else $error("memory gated pulse cut");
    a_mem_fanout: assert property (mem_clk_gated == {16{mem_clk_gated[0]}})
        else $error("memory copies differ");
    a_mem_stop: assert property (cstop_q == 6'h28 |-> mem_clk_gated == 16'h0)
        else $error("memory outputs not stopped");
    a_mem_free: assert property ($past(aresetn) |-> mem_clk_free == $past(mem_clk_source))
        else $error("free memory copy wrong");
endmodule

bind csg_clock_strap csg_clock_strap_props #(.SEL_CYCLES(SEL_CYCLES)) u_csg_clock_strap_props (
    .aclk(aclk), .aresetn(aresetn), .power_good(power_good), .ref_clk_in(ref_clk_in),
    .clk24_in(clk24_in), .mem_clk_source(mem_clk_source), .clk_stop_n(clk_stop_n),
    .fixed_ref_out_a_in(fixed_ref_out_a_in), .freq_sel_bit0_in(freq_sel_bit0_in),
    .freq_sel_bit1_in(freq_sel_bit1_in), .freq_sel_bit2_in(freq_sel_bit2_in),
    .freq_sel_bit3_in(freq_sel_bit3_in), .mode_pin_in(mode_pin_in),
    .freq_sel_bit0_out(freq_sel_bit0_out), .freq_sel_bit0_oe(freq_sel_bit0_oe),
    .mode_pin_out(mode_pin_out), .mode_pin_oe(mode_pin_oe),
    .fixed_ref_out_a_out(fixed_ref_out_a_out), .fixed_ref_out_a_oe(fixed_ref_out_a_oe),
    .pci_clk_gated(pci_clk_gated), .mem_clk_gated(mem_clk_gated), .mem_clk_free(mem_clk_free),
    .freq_sel_code(freq_sel_code), .mode_strap(mode_strap));
`default_nettype wire

/* bench/csg_chipset_model.sv */
// Board-side model: strap resistors on the dual pins and the chipset's stop inputs.
`timescale 1ns/1ps
`default_nettype none
module csg_chipset_model (
    // Requests from the bench
    input wire logic [4:0] strap,
    input wire logic pci_run,
    input wire logic mem_run,
    // Pin drivers of the block
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic ref_out,
    input wire logic ref_oe,
    // Pin levels seen by the block
    output logic [4:0] pin_lvl,
    output logic ref_lvl,
    output logic clk_stop_n
);
    // An undriven dual pin settles to the level of its strap resistor.
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & strap);
    assign ref_lvl = ref_oe ? ref_out : pci_run;
    assign clk_stop_n = mem_run;
endmodule
`default_nettype wire

/* bench/csg_clock_strap_tb_top.sv */
// Self-checking bench for the clock strap block.
`timescale 1ns/1ps
`default_nettype none
`include "csg_map.vh"
module csg_clock_strap_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic power_good = 1'b0;
    logic [3:0] cnt_q = 4'h0;
    logic [4:0] strap = 5'h0;
    logic pci_run = 1'b1;
    logic mem_run = 1'b1;
    logic [4:0] pin_lvl, pin_out, pin_oe, pci_g, st;
    logic ref_lvl, ref_out, ref_oe, clk_stop_n, cpu_f, mem_f, mode_strap;
    logic [1:0] cpu_g, bresp, rresp;
    logic [15:0] mem_g;
    logic [3:0] fs_code;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rnd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int mismatches = 0;
    int total_checks = 0;
    int seed = 32'h4dab6e0e;

    csg_clock_strap #(.SEL_CYCLES(8)) u_csg_clock_strap (
        .aclk(aclk), .aresetn(aresetn), .power_good(power_good),
        .ref_clk_in(cnt_q[2]), .pci_clk_in(cnt_q[3]), .cpu_clk_in(cnt_q[1]),
        .clk24_in(cnt_q[2]), .clk48_in(cnt_q[1]), .mem_clk_source(cnt_q[2]),
        .clk_stop_n(clk_stop_n),
        .freq_sel_bit0_in(pin_lvl[0]), .freq_sel_bit0_out(pin_out[0]), .freq_sel_bit0_oe(pin_oe[0]),
        .freq_sel_bit1_in(pin_lvl[1]), .freq_sel_bit1_out(pin_out[1]), .freq_sel_bit1_oe(pin_oe[1]),
        .freq_sel_bit2_in(pin_lvl[2]), .freq_sel_bit2_out(pin_out[2]), .freq_sel_bit2_oe(pin_oe[2]),
        .freq_sel_bit3_in(pin_lvl[3]), .freq_sel_bit3_out(pin_out[3]), .freq_sel_bit3_oe(pin_oe[3]),
        .mode_pin_in(pin_lvl[4]), .mode_pin_out(pin_out[4]), .mode_pin_oe(pin_oe[4]),
        .fixed_ref_out_a_in(ref_lvl), .fixed_ref_out_a_out(ref_out), .fixed_ref_out_a_oe(ref_oe),
        .pci_clk_gated(pci_g), .cpu_clk_gated(cpu_g), .cpu_clk_free(cpu_f),
        .mem_clk_gated(mem_g), .mem_clk_free(mem_f), .freq_sel_code(fs_code),
        .mode_strap(mode_strap),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    csg_chipset_model u_csg_chipset_model (
        .strap(strap), .pci_run(pci_run), .mem_run(mem_run), .pin_out(pin_out),
        .pin_oe(pin_oe), .ref_out(ref_out), .ref_oe(ref_oe), .pin_lvl(pin_lvl),
        .ref_lvl(ref_lvl), .clk_stop_n(clk_stop_n));

    always #2 aclk = ~aclk;
    always @(posedge aclk) cnt_q <= cnt_q + 4'h1;

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        int n;
        wq.push_back(er);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        if (n >= 100) mismatches++;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [33:0] exp);
        int n;
        rq.push_back(exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        if (n >= 100) mismatches++;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Takes the oldest expected answer whenever a response is accepted.
    always @(posedge aclk) begin
        if (bvalid && bready && wq.size() > 0) check({32'h0, bresp}, {32'h0, wq.pop_front()});
        if (rvalid && rready && rq.size() > 0) check({rresp, rdata}, rq.pop_front());
    end

    // Notes which outputs were seen high over three slow periods.
    task automatic watch(input logic [5:0] exp);
        logic [5:0] hi;
        hi = 6'h0;
        repeat (48) begin
            @(posedge aclk);
            hi |= {ref_out, pci_g[0], pin_out[4], mem_g[0], mem_f, cpu_f};
        end
        check(hi, exp);
    endtask

    task automatic power_up(input logic [4:0] s);
        int n;
        power_good <= 1'b0;
        strap <= s;
        cycles(4);
        check(pin_oe, 5'h0);
        power_good <= 1'b1;
        n = 0;
        while (pin_oe[0] !== 1'b1 && n < 500) begin
            @(posedge aclk);
            n++;
            if (n == 20) check(pin_oe, 5'h0);
        end
        if (n >= 500) mismatches++;
        cycles(40);
        check({ref_oe, mode_strap, fs_code}, {s[4], s});
    endtask

    initial begin
        #200000;
        mismatches++;
        give_verdict;
    end

    initial begin
        cycles(2);
        aresetn <= 1'b1;
        rnd = $random(seed);
        st = {1'b0, rnd[3:0]};
        power_up(st);
        axi_read(`CSG_ADDR_STATUS, {24'h0, 5'h1f, st});
        aresetn <= 1'b0;
        cycles(2);
        aresetn <= 1'b1;
        strap <= ~st;
        cycles(40);
        check({mode_strap, fs_code}, st);
        watch(6'h1f);
        pci_run <= 1'b0;
        cycles(40);
        check({pin_out[3], pci_g}, 6'h0);
        watch(6'h0f);
        pci_run <= 1'b1;
        mem_run <= 1'b0;
        cycles(40);
        watch(6'h1b);
        check(cpu_g, 2'h0);
        mem_run <= 1'b1;
        cycles(40);
        axi_write(`CSG_ADDR_CTRL, 32'h7, 4'hf, `CSG_RESP_OKAY);
        axi_read(`CSG_ADDR_CTRL, 34'h7);
        cycles(40);
        watch(6'h0b);
        axi_write(`CSG_ADDR_CTRL, 32'h0, 4'h0, `CSG_RESP_OKAY);
        axi_read(`CSG_ADDR_CTRL, 34'h7);
        axi_write(`CSG_ADDR_STATUS, 32'h0, 4'hf, `CSG_RESP_OKAY);
        axi_write(4'h8, 32'h0, 4'hf, `CSG_RESP_SLVERR);
        axi_read(4'hc, {`CSG_RESP_SLVERR, 32'h0});
        repeat (4) begin
            rnd = $random(seed);
            axi_write(`CSG_ADDR_CTRL, rnd, 4'hf, `CSG_RESP_OKAY);
            axi_read(`CSG_ADDR_CTRL, {31'h0, rnd[2:0]});
        end
        axi_write(`CSG_ADDR_CTRL, 32'h0, 4'hf, `CSG_RESP_OKAY);
        cycles(40);
        axi_read(`CSG_ADDR_STATUS, {24'h0, 5'h1f, st});
        st = {1'b1, rnd[7:4]};
        power_up(st);
        pci_run <= 1'b0;
        cycles(40);
        watch(6'h3f);
        give_verdict;
    end
endmodule
`default_nettype wire
